// ===== rtl/pbpc_pkg.sv
// Package with shared constants for the primary-side bridge control block
package pbpc_pkg;
    localparam int          REQ_GAP_CYCLES  = 2;
    localparam logic [1:0]  REQ_GAP_RESET   = 2'h0;
    localparam int          ERR_SRC_COUNT   = 10;
    localparam int          AD_WIDTH        = 32;
    localparam int          CBE_WIDTH       = 4;
    localparam logic [31:0] PARK_AD_VALUE   = 32'h0000_0000;
    localparam logic [3:0]  PARK_CBE_VALUE  = 4'h0;

    typedef enum logic [1:0] {PBPC_IDLE, PBPC_REQ, PBPC_OWN, PBPC_GAP} pbpc_state_t;

    // Even parity over address/data and command/byte enables
    function automatic logic pbpc_parity(input logic [31:0] ad, input logic [3:0] cbe);
        pbpc_parity = ^{ad, cbe};
    endfunction : pbpc_parity
endpackage : pbpc_pkg

// ===== rtl/pbpc_if.sv
// Interface joining the bridge primary side and the arbiter/host side
`timescale 1ns/1ps
interface pbpc_if;
    logic        mclk;
    logic        resetn;
    logic        req_n;
    logic        req_oe_n;
    logic        gnt_n;
    logic        frame_n;
    logic        bridge_frame_n;
    logic        bridge_frame_oe_n;
    logic        primary_system_error_n;
    logic        serr_bridge_oe_n;
    logic        serr_host_oe_n;
    logic [31:0] ad_out;
    logic        ad_oe_n;
    logic [3:0]  primary_cmd_byte_enable;
    logic        primary_parity;
    logic        primary_fast_clock_enable;
    logic        secondary_fast_clock_enable;

    // Open-drain line: low when any party enables its driver
    assign primary_system_error_n = serr_bridge_oe_n & serr_host_oe_n;

    modport bridge (
        input  mclk, resetn, gnt_n, frame_n, primary_system_error_n,
               primary_fast_clock_enable, secondary_fast_clock_enable,
        output req_n, req_oe_n, bridge_frame_n, bridge_frame_oe_n, serr_bridge_oe_n,
               ad_out, ad_oe_n, primary_cmd_byte_enable, primary_parity
    );
    modport host (
        input  mclk, resetn, req_n, req_oe_n, bridge_frame_n, bridge_frame_oe_n,
               primary_system_error_n,
        output gnt_n, frame_n, serr_host_oe_n,
               primary_fast_clock_enable, secondary_fast_clock_enable
    );
endinterface : pbpc_if

// ===== rtl/pbpc_bridge.sv
// Bridge end: primary request pacing, parking, system error and reset tri-state
`timescale 1ns/1ps
module pbpc_bridge (
    pbpc_if.bridge      bus,
    input  wire logic   start_req,
    input  wire logic   xfer_done,
    input  wire logic   err_addr_parity,
    input  wire logic   err_posted_data_parity,
    input  wire logic   err_posted_master_abort,
    input  wire logic   err_posted_target_abort,
    input  wire logic   err_posted_discard,
    input  wire logic   err_delayed_write_discard,
    input  wire logic   err_delayed_read_discard,
    input  wire logic   err_delayed_timeout,
    input  wire logic   secondary_system_error_n,
    output logic        owner,
    output logic        fast_mode,
    output logic        clock_config_error
);
    // Request state and the quiet counter that follows a release
    pbpc_pkg::pbpc_state_t state_q;
    pbpc_pkg::pbpc_state_t state_d;
    logic [1:0]            gap_q;
    logic [1:0]            gap_d;
    // Registered error pull, park enable and strap capture
    logic                  serr_q;
    logic                  park_q;
    logic                  mode_q;
    logic                  cfg_err_q;

    // Decoded views of the bus and of the request state
    logic                  granted;
    logic                  bus_idle;
    logic                  in_req;
    logic                  in_own;
    logic                  take_bus;
    logic                  gap_done;
    logic                  park_d;
    logic                  drive_ad;

    // Error conditions, one net per reported group
    logic                  parity_err;
    logic                  sec_err;
    logic                  posted_abort_err;
    logic                  posted_drop_err;
    logic                  delayed_drop_err;
    logic                  delayed_tmo_err;
    logic                  any_err;

    // Next quiet count; saturates so a stuck state can never wrap it
    function automatic logic [1:0] gap_step(input logic [1:0] count);
        if (count == 2'h3) begin
            gap_step = count;
        end else begin
            gap_step = count + 2'h1;
        end
    endfunction : gap_step

    assign granted  = ~bus.gnt_n;
    assign bus_idle = bus.frame_n;
    assign in_req   = (state_q == pbpc_pkg::PBPC_REQ);
    assign in_own   = (state_q == pbpc_pkg::PBPC_OWN);
    // A transfer may only begin on a granted, idle bus
    assign take_bus = in_req & granted & bus_idle;
    assign gap_done = (gap_q == 2'(pbpc_pkg::REQ_GAP_CYCLES - 1));

    // Inputs are synchronous to mclk, so the secondary line needs no stage.
    // It is a separate pin: reading the primary line would echo our own pull.
    assign parity_err       = err_addr_parity
                            | err_posted_data_parity;
    assign sec_err          = ~secondary_system_error_n;
    assign posted_abort_err = err_posted_master_abort
                            | err_posted_target_abort;
    assign posted_drop_err  = err_posted_discard;
    assign delayed_drop_err = err_delayed_write_discard
                            | err_delayed_read_discard;
    assign delayed_tmo_err  = err_delayed_timeout;
    // No priority: any group pulls the line; a held secondary error holds it
    assign any_err          = parity_err
                            | sec_err
                            | posted_abort_err
                            | posted_drop_err
                            | delayed_drop_err
                            | delayed_tmo_err;

    // Park only while granted, idle and not holding the bus ourselves
    assign park_d   = granted & bus_idle & ~in_own;
    assign drive_ad = park_q | in_own;

    // Request sequencing; a new start is ignored while owning or quiet
    always_comb begin
        state_d = state_q;
        gap_d   = gap_q;
        unique case (state_q)
            pbpc_pkg::PBPC_IDLE: begin
                if (start_req) begin
                    state_d = pbpc_pkg::PBPC_REQ;
                end
            end
            pbpc_pkg::PBPC_REQ: begin
                if (take_bus) begin
                    state_d = pbpc_pkg::PBPC_OWN;
                end
            end
            pbpc_pkg::PBPC_OWN: begin
                if (xfer_done) begin
                    state_d = pbpc_pkg::PBPC_GAP;
                    gap_d   = pbpc_pkg::REQ_GAP_RESET;
                end
            end
            pbpc_pkg::PBPC_GAP: begin
                gap_d = gap_step(gap_q);
                if (gap_done) begin
                    state_d = pbpc_pkg::PBPC_IDLE;
                end
            end
        endcase
    end

    // State and counter share the asynchronous reset
    always_ff @(posedge bus.mclk or negedge bus.resetn) begin
        if (!bus.resetn) begin
            state_q <= pbpc_pkg::PBPC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge bus.mclk or negedge bus.resetn) begin
        if (!bus.resetn) begin
            gap_q <= pbpc_pkg::REQ_GAP_RESET;
        end else begin
            gap_q <= gap_d;
        end
    end

    // Follows any_err one cycle later; reset releases the line at once
    always_ff @(posedge bus.mclk or negedge bus.resetn) begin
        if (!bus.resetn) begin
            serr_q <= 1'b0;
        end else begin
            serr_q <= any_err;
        end
    end

    // Registered so the park enable never follows a glitch on the grant
    always_ff @(posedge bus.mclk or negedge bus.resetn) begin
        if (!bus.resetn) begin
            park_q <= 1'b0;
        end else begin
            park_q <= park_d;
        end
    end

    // The primary fast-clock strap is sampled on every clock out of reset, never under reset
    always_ff @(posedge bus.mclk or negedge bus.resetn) begin
        if (!bus.resetn) begin
            mode_q <= 1'b0;
        end else begin
            mode_q <= bus.primary_fast_clock_enable;
        end
    end

    // Flags a slow primary with a fast secondary; the host should prevent it
    always_ff @(posedge bus.mclk or negedge bus.resetn) begin
        if (!bus.resetn) begin
            cfg_err_q <= 1'b0;
        end else begin
            cfg_err_q <= ~bus.primary_fast_clock_enable
                       & bus.secondary_fast_clock_enable;
        end
    end

    // Status seen by the bridge core
    assign owner              = in_own;
    assign fast_mode          = mode_q;
    assign clock_config_error = cfg_err_q;

    // Request pin: low only in REQ, so the quiet states keep it high
    assign bus.req_n             = ~in_req;
    // Every output enable is forced high by reset alone, with no clock
    assign bus.req_oe_n          = ~bus.resetn;
    assign bus.bridge_frame_n    = ~in_own;
    assign bus.bridge_frame_oe_n = ~bus.resetn | ~in_own;
    // Open-drain: enable the driver only to pull low, never drive high
    assign bus.serr_bridge_oe_n  = ~(serr_q & bus.resetn);
    // Parked levels are constants with matching parity
    assign bus.ad_out                  = pbpc_pkg::PARK_AD_VALUE;
    assign bus.primary_cmd_byte_enable = pbpc_pkg::PARK_CBE_VALUE;
    assign bus.primary_parity          = pbpc_pkg::pbpc_parity(pbpc_pkg::PARK_AD_VALUE,
                                                               pbpc_pkg::PARK_CBE_VALUE);
    assign bus.ad_oe_n                 = ~bus.resetn | ~drive_ad;
endmodule : pbpc_bridge

// ===== rtl/pbpc_host.sv
// Arbiter and host end: grants the bus, drives straps and may raise system error
`timescale 1ns/1ps
module pbpc_host (
    pbpc_if.host        bus,
    input  wire logic   grant_enable,
    input  wire logic   host_error,
    input  wire logic   fast_select,
    input  wire logic   secondary_fast_select,
    output logic        system_error_seen,
    output logic        bridge_owns_bus
);
    logic gnt_q;
    logic err_q;
    logic seen_q;

    // Grant follows grant_enable alone, not the request; parking grant kept when enabled
    wire gnt_d = grant_enable;

    always_ff @(posedge bus.mclk or negedge bus.resetn) begin
        if (!bus.resetn) begin
            gnt_q  <= 1'b0;
            err_q  <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            gnt_q  <= gnt_d;
            err_q  <= host_error;
            seen_q <= ~bus.primary_system_error_n;
        end
    end

    assign bus.gnt_n          = ~gnt_q;
    assign bus.frame_n        = bus.bridge_frame_oe_n | bus.bridge_frame_n;
    assign bus.serr_host_oe_n = ~err_q;
    assign bus.primary_fast_clock_enable   = fast_select;
    // Secondary may only run fast when primary does
    assign bus.secondary_fast_clock_enable = fast_select & secondary_fast_select;
    assign system_error_seen  = seen_q;
    assign bridge_owns_bus    = ~bus.frame_n;
endmodule : pbpc_host

// ===== bench/pbpc_assertions.sv
// Checker for request pacing, grant use and parking on the primary side
`timescale 1ns/1ps
module pbpc_assertions (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        req_n,
    input wire logic        gnt_n,
    input wire logic        frame_n,
    input wire logic        bridge_frame_oe_n,
    input wire logic        serr_bridge_oe_n,
    input wire logic [31:0] ad_out,
    input wire logic        ad_oe_n,
    input wire logic [3:0]  primary_cmd_byte_enable,
    input wire logic        primary_parity
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    req_gap_a: assert property ($rose(req_n) |=> req_n [*2])
        else $error("request raised again too soon");
    end_gap_a: assert property ($rose(bridge_frame_oe_n) |-> req_n ##1 req_n)
        else $error("request too soon after ownership");
    req_hold_a: assert property (!req_n && (gnt_n || !frame_n) |=> !req_n)
        else $error("request dropped before grant");
    own_grant_a: assert property (!req_n && !gnt_n && frame_n |=> req_n && !bridge_frame_oe_n)
        else $error("grant not taken");
    frame_gnt_a: assert property ($fell(bridge_frame_oe_n) |-> !$past(gnt_n))
        else $error("frame driven without grant");
    park_drive_a: assert property ((!gnt_n && frame_n) [*2] |-> !ad_oe_n)
        else $error("idle granted bus not parked");
    park_value_a: assert property (!ad_oe_n && bridge_frame_oe_n |->
        ad_out == pbpc_pkg::PARK_AD_VALUE && primary_cmd_byte_enable == pbpc_pkg::PARK_CBE_VALUE)
        else $error("park value wrong");
    park_parity_a: assert property (!ad_oe_n |-> primary_parity == ^{ad_out, primary_cmd_byte_enable})
        else $error("parity wrong");
    cover property ($fell(req_n));
    cover property ($rose(bridge_frame_oe_n));
    cover property (!serr_bridge_oe_n);
endmodule : pbpc_assertions

// ===== bench/pci_bridge_primary_control_test.sv
// Testbench joining the bridge and host ends over the primary-side interface
`timescale 1ns/1ps
module pci_bridge_primary_control_test;
    pbpc_if     bus ();
    logic       start_req, xfer_done, grant_enable, host_error, fast_select, sec_fast;
    logic [7:0] err;
    logic       owner, fast_mode, cfg_err, owns, sec_serr_n, sys_err_seen;
    int         error_cnt, tests_run, i;
    pbpc_bridge i_pbpc_bridge (.bus(bus), .start_req(start_req), .xfer_done(xfer_done),
        .err_addr_parity(err[0]), .err_posted_data_parity(err[1]),
        .err_posted_master_abort(err[2]), .err_posted_target_abort(err[3]),
        .err_posted_discard(err[4]), .err_delayed_write_discard(err[5]),
        .err_delayed_read_discard(err[6]), .err_delayed_timeout(err[7]),
        .secondary_system_error_n(sec_serr_n), .owner(owner),
        .fast_mode(fast_mode), .clock_config_error(cfg_err));
    pbpc_host i_pbpc_host (.bus(bus), .grant_enable(grant_enable), .host_error(host_error),
        .fast_select(fast_select), .secondary_fast_select(sec_fast),
        .system_error_seen(sys_err_seen), .bridge_owns_bus(owns));
    pbpc_assertions i_pbpc_assertions (.mclk(bus.mclk), .resetn(bus.resetn), .req_n(bus.req_n),
        .gnt_n(bus.gnt_n), .frame_n(bus.frame_n), .bridge_frame_oe_n(bus.bridge_frame_oe_n),
        .serr_bridge_oe_n(bus.serr_bridge_oe_n), .ad_out(bus.ad_out), .ad_oe_n(bus.ad_oe_n),
        .primary_cmd_byte_enable(bus.primary_cmd_byte_enable),
        .primary_parity(bus.primary_parity));
    always #12.5 bus.mclk = ~bus.mclk;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Inputs change 2 ns after the edge, clear of the sampling point
    task automatic tick(input int n);
        repeat (n) @(posedge bus.mclk);
        #2;
    endtask : tick
    task automatic results();
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic t_req();
        start_req = 1;
        tick(1);
        chk(bus.req_n, 0);
        chk(owner, 0);
        grant_enable = 1;
        for (i = 0; i < 20 && !owner; i++) tick(1);
        chk({owns, bus.req_n}, 2'h3);
        xfer_done = 1;
        tick(1);
        xfer_done = 0;
        for (i = 0; i < 3; i++) begin
            chk(bus.req_n, 1);
            tick(1);
        end
        chk(bus.req_n, 0);
        start_req = 0;
        for (i = 0; i < 20 && !owner; i++) tick(1);
        xfer_done = 1;
        tick(1);
        xfer_done = 0;
        tick(4);
        chk({bus.ad_oe_n, bus.ad_out}, {1'b0, pbpc_pkg::PARK_AD_VALUE});
    endtask : t_req
    task automatic t_err();
        for (i = 0; i < 10; i++) begin
            if (i < 8) err[i] = 1;
            else if (i == 8) host_error = 1;
            else sec_serr_n = 0;
            tick(1);
            err = 8'h00;
            host_error = 0;
            sec_serr_n = 1;
            chk(bus.primary_system_error_n, 0);
            tick(1);
            chk({sys_err_seen, bus.primary_system_error_n}, 2'h3);
            tick(1);
        end
    endtask : t_err
    task automatic t_speed();
        sec_fast = 1;
        tick(2);
        chk({fast_mode, cfg_err, bus.secondary_fast_clock_enable}, 3'h5);
        fast_select = 0;
        tick(2);
        chk({fast_mode, cfg_err, bus.secondary_fast_clock_enable}, 3'h0);
        sec_fast = 0;
        tick(2);
        chk({fast_mode, cfg_err, bus.secondary_fast_clock_enable}, 3'h0);
    endtask : t_speed
    // Reset lands mid-cycle so the tri-state cannot lean on a clock edge
    task automatic t_reset();
        #5 bus.resetn = 0;
        #1 chk({bus.req_oe_n, bus.ad_oe_n, bus.serr_bridge_oe_n, bus.bridge_frame_oe_n}, 4'hf);
        grant_enable = 0;
        tick(2);
        bus.resetn = 1;
        tick(1);
    endtask : t_reset
    initial begin
        {bus.mclk, bus.resetn, start_req, xfer_done, grant_enable, host_error} = 6'h00;
        {fast_select, sec_fast, err, error_cnt, tests_run} = '0;
        fast_select = 1;
        sec_serr_n = 1;
        tick(10);
        bus.resetn = 1;
        tick(1);
        t_req();
        t_err();
        t_speed();
        t_reset();
        t_req();
        results();
    end
    initial begin
        #50000;
        error_cnt++;
        results();
    end
endmodule : pci_bridge_primary_control_test
